//--- design/emulated_eeprom_access_ctrl.sv
/*
  Emulated EEPROM access controller: address, control and data
  registers, a 32-word array, and the read, write and erase sequencer
  that stalls the CPU while a cycle runs.
  Assumes a single-cycle register port from the CPU on clk, and a
  low-power entry strobe from the CPU clock logic on the same clock.
*/
`timescale 1ns/1ps
`include "eeprom_defs.svh"

module emulated_eeprom_access_ctrl #(
  // Cycles for the shortest program time; shorten in simulation
  parameter int unsigned BASE_CYCLES =
    (`EE_BASE_TIME_US * 1000) / `EE_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire eeprom_pkg::reg_index_type addr,
  input wire eeprom_pkg::byte_type wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic low_power_entry,
  output eeprom_pkg::byte_type rdata,
  output logic cpu_stall,
  output logic op_fail
);
  import eeprom_pkg::*;

  // Read access time in cycles, rounded up, never below one
  localparam int unsigned READ_CYCLES_RAW =
    (`EE_READ_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS;
  localparam int unsigned READ_CYCLES =
    (READ_CYCLES_RAW < 1) ? 1 : READ_CYCLES_RAW;

  // Software visible registers
  logic [4:0] eeprom_address_reg; // Word address
  byte_type eeprom_control_reg; // Enables, triggers, time select
  byte_type data_low_reg [4]; // Low bytes of the four data pairs
  byte_type data_high_reg [4]; // High bytes of the four data pairs

  // Array and sequencer
  word_type mem_reg [`EE_WORDS]; // Emulated nonvolatile words
  ee_state_type state_reg; // Sequencer state
  ee_state_type state_next; // Next sequencer state
  logic arm_write_reg; // Write enable set by the last access
  logic arm_erase_reg; // Erase enable set by the last access
  byte_type rdata_reg; // Read data, one cycle after strobe
  logic cpu_stall_reg; // Halt request toward the CPU
  logic op_fail_reg; // Last cycle aborted by low power entry

  // Decode and control wires
  logic idle_w; // No cycle running
  logic busy_w; // A cycle is running
  logic addr_wr_w; // Address register write accepted
  logic ctrl_wr_w; // Control register write accepted
  logic data_hit_w; // Strobe addresses a data register
  logic data_wr_w; // Data register write accepted
  logic [1:0] pair_w; // Addressed data pair
  logic [2:0] trig_new_w; // Trigger bits newly requested
  logic single_trig_w; // Exactly one trigger requested
  logic go_read_w; // Read cycle activated
  logic go_write_w; // Write cycle activated
  logic go_erase_w; // Erase cycle activated
  logic go_any_w; // Any cycle activated
  logic cycle_done_w; // Timer reached the end of the cycle
  logic abort_w; // Cycle killed by low power entry
  logic finish_w; // Normal end of a cycle
  logic read_end_w; // Normal end of a read
  logic write_end_w; // Normal end of a write
  logic erase_end_w; // Normal end of an erase
  count_type prog_cycles_w; // Selected program time in cycles
  count_type load_cycles_w; // Count handed to the timer
  byte_type ctrl_written_w; // Control value after a write
  byte_type ctrl_next; // Next control register value
  byte_type rd_mux_w; // Selected read data
  word_type read_word_w; // Word picked by the address

  assign idle_w = (state_reg == ST_IDLE);
  assign busy_w = !idle_w;

  // Register writes only land while idle
  assign addr_wr_w = wr_en && idle_w && (addr == `EE_IDX_ADDR);
  assign ctrl_wr_w = wr_en && idle_w && (addr == `EE_IDX_CTRL);
  assign data_hit_w = (addr >= `EE_IDX_DATA_FIRST) && (addr <= `EE_IDX_DATA_LAST);
  assign data_wr_w = wr_en && idle_w && data_hit_w;
  assign pair_w = 2'(addr[3:1] - 3'h1);

  // Triggers that go from zero to one in this write
  assign trig_new_w = {wdata[`CTL_ER_TRIG], wdata[`CTL_WR_TRIG], wdata[`CTL_RD_TRIG]}
    & ~{eeprom_control_reg[`CTL_ER_TRIG], eeprom_control_reg[`CTL_WR_TRIG],
        eeprom_control_reg[`CTL_RD_TRIG]};
  assign single_trig_w = (trig_new_w == 3'b001) || (trig_new_w == 3'b010)
    || (trig_new_w == 3'b100);

  // Read needs its enable already high
  assign go_read_w = ctrl_wr_w && single_trig_w && trig_new_w[0]
    && eeprom_control_reg[`CTL_RD_EN];

  // Write and erase also need the enable set by the previous access
  assign go_write_w = ctrl_wr_w && single_trig_w && trig_new_w[1]
    && eeprom_control_reg[`CTL_WR_EN] && arm_write_reg;
  assign go_erase_w = ctrl_wr_w && single_trig_w && trig_new_w[2]
    && eeprom_control_reg[`CTL_ER_EN] && arm_erase_reg;
  assign go_any_w = go_read_w || go_write_w || go_erase_w;

  // Program time doubles with each step of the select field
  assign prog_cycles_w = count_type'(BASE_CYCLES)
    << wdata[`CTL_TSEL_HI:`CTL_TSEL_LO];
  assign load_cycles_w = go_read_w ? count_type'(READ_CYCLES) : prog_cycles_w;

  // End of cycle, either clean or aborted
  assign abort_w = busy_w && low_power_entry;
  assign finish_w = busy_w && cycle_done_w && !abort_w;
  assign read_end_w = finish_w && (state_reg == ST_READ);
  assign write_end_w = finish_w && (state_reg == ST_WRITE);
  assign erase_end_w = finish_w && (state_reg == ST_ERASE);

  // Value stored by a control write; an ignored trigger stays low
  assign ctrl_written_w = {wdata[`CTL_TSEL_HI:`CTL_TSEL_LO], wdata[`CTL_ER_EN], go_erase_w,
    wdata[`CTL_WR_EN], go_write_w, wdata[`CTL_RD_EN], go_read_w};

  // Word at the current address, for reads
  assign read_word_w = mem_reg[eeprom_address_reg];

  // Register read multiplexer; unmapped indices read zero
  assign rd_mux_w = (addr == `EE_IDX_ADDR) ? {3'h0, eeprom_address_reg} :
    (addr == `EE_IDX_CTRL) ? eeprom_control_reg :
    !data_hit_w ? 8'h00 :
    addr[0] ? data_high_reg[pair_w] : data_low_reg[pair_w];

  // Cycle timer
  eeprom_cycle_timer eeprom_cycle_timer_i (
    .clk(clk),
    .rst_n(rst_n),
    .start(go_any_w),
    .abort(abort_w),
    .load_count(load_cycles_w),
    .done(cycle_done_w)
  );

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // New cycle only from idle
        if (go_read_w) begin
          state_next = ST_READ;
        end else if (go_write_w) begin
          state_next = ST_WRITE;
        end else if (go_erase_w) begin
          state_next = ST_ERASE;
        end
      end
      ST_READ, ST_WRITE, ST_ERASE: begin
        // Busy: requests ignored, leave on end or abort
        if (finish_w || abort_w) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Control register next value
  always_comb begin
    ctrl_next = eeprom_control_reg;
    if (ctrl_wr_w) begin
      // Software write, accepted only while idle
      ctrl_next = ctrl_written_w;
    end else if (read_end_w) begin
      ctrl_next[`CTL_RD_TRIG] = 1'b0;
    end else if (write_end_w) begin
      ctrl_next[`CTL_WR_TRIG] = 1'b0;
      ctrl_next[`CTL_WR_EN] = 1'b0;
    end else if (erase_end_w) begin
      ctrl_next[`CTL_ER_TRIG] = 1'b0;
      ctrl_next[`CTL_ER_EN] = 1'b0;
    end else if (abort_w) begin
      // Failed cycle drops every trigger and program enable
      ctrl_next[`CTL_RD_TRIG] = 1'b0;
      ctrl_next[`CTL_WR_TRIG] = 1'b0;
      ctrl_next[`CTL_WR_EN] = 1'b0;
      ctrl_next[`CTL_ER_TRIG] = 1'b0;
      ctrl_next[`CTL_ER_EN] = 1'b0;
    end
  end

  // Sequencer and control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      eeprom_control_reg <= `CTL_RESET;
    end else begin
      state_reg <= state_next;
      eeprom_control_reg <= ctrl_next;
    end
  end

  // Arming: an enable rising marks the very next access as the trigger slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_write_reg <= 1'b0;
      arm_erase_reg <= 1'b0;
    end else if (wr_en || rd_en) begin
      arm_write_reg <= ctrl_wr_w && wdata[`CTL_WR_EN]
        && !eeprom_control_reg[`CTL_WR_EN];
      arm_erase_reg <= ctrl_wr_w && wdata[`CTL_ER_EN]
        && !eeprom_control_reg[`CTL_ER_EN];
    end
  end

  // Address register, never stepped by hardware
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_address_reg <= `ADDR_RESET;
    end else if (addr_wr_w) begin
      eeprom_address_reg <= wdata[4:0];
    end
  end

  // Data register pairs; pair zero also takes the read result
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pair
      logic lo_wr_w; // Software write to this low byte
      logic hi_wr_w; // Software write to this high byte
      logic load_w; // Read result lands here
      assign lo_wr_w = data_wr_w && (pair_w == 2'(p)) && !addr[0];
      assign hi_wr_w = data_wr_w && (pair_w == 2'(p)) && addr[0];
      assign load_w = read_end_w && (p == 0);

      // Byte pair update
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          data_low_reg[p] <= `DATA_RESET;
          data_high_reg[p] <= `DATA_RESET;
        end else if (load_w) begin
          // Held until the next read or a software write replaces it
          data_low_reg[p] <= read_word_w[7:0];
          data_high_reg[p] <= read_word_w[15:8];
        end else begin
          data_low_reg[p] <= lo_wr_w ? wdata : data_low_reg[p];
          data_high_reg[p] <= hi_wr_w ? wdata : data_high_reg[p];
        end
      end
    end
  endgenerate

  // Array words: write unit of four, erase page of sixteen
  genvar w;
  generate
    for (w = 0; w < `EE_WORDS; w++) begin : g_word
      logic unit_hit_w; // Word lies in the addressed write unit
      logic page_hit_w; // Word lies in the addressed erase page
      assign unit_hit_w = (3'(w >> 2) == eeprom_address_reg[4:2]);
      assign page_hit_w = (1'(w >> 4) == eeprom_address_reg[4]);

      // Commit only on a clean end; an aborted cycle leaves the word
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_reg[w] <= `WORD_RESET;
        end else if (write_end_w && unit_hit_w) begin
          mem_reg[w] <= {data_high_reg[w % 4], data_low_reg[w % 4]};
        end else if (erase_end_w && page_hit_w) begin
          mem_reg[w] <= `WORD_RESET;
        end
      end
    end
  endgenerate

  // CPU halt from activation to the end of the cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_stall_reg <= 1'b0;
    end else begin
      cpu_stall_reg <= go_any_w || (busy_w && !finish_w && !abort_w);
    end
  end

  // Failure flag: set by abort, cleared by the next activation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_fail_reg <= 1'b0;
    end else if (abort_w) begin
      op_fail_reg <= 1'b1;
    end else if (go_any_w) begin
      op_fail_reg <= 1'b0;
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_en ? rd_mux_w : 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign cpu_stall = cpu_stall_reg;
  assign op_fail = op_fail_reg;

endmodule

//--- pkg/eeprom_defs.svh
/*
  Constants of the emulated EEPROM access controller: register indices,
  control field positions, reset values and cycle timing figures.
  Assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// Register indices on the plain register port
`define EE_IDX_ADDR 4'h0
`define EE_IDX_CTRL 4'h1
`define EE_IDX_DATA_FIRST 4'h2
`define EE_IDX_DATA_LAST 4'h9

// Control register field positions
`define CTL_RD_TRIG 0
`define CTL_RD_EN 1
`define CTL_WR_TRIG 2
`define CTL_WR_EN 3
`define CTL_ER_TRIG 4
`define CTL_ER_EN 5
`define CTL_TSEL_LO 6
`define CTL_TSEL_HI 7

// Reset values
`define CTL_RESET 8'h00
`define ADDR_RESET 5'h00
`define DATA_RESET 8'h00
`define WORD_RESET 16'h0000

// Array geometry
`define EE_WORDS 32
`define TIMER_W 24

// Timing: clock period, shortest program time, read access time
`define EE_CLK_PERIOD_NS 4
`define EE_BASE_TIME_US 2000
`define EE_READ_TIME_NS 16

`endif

//--- pkg/eeprom_pkg.sv
/*
  Types shared by the emulated EEPROM access controller and its timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eeprom_pkg;

  // Bus byte and stored word
  typedef logic [7:0] byte_type;
  typedef logic [15:0] word_type;
  typedef logic [3:0] reg_index_type;
  typedef logic [23:0] count_type;

  // Sequencer states, Gray coded along idle-read-write-erase
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11,
    ST_ERASE = 2'b10
  } ee_state_type;

endpackage

//--- design/eeprom_cycle_timer.sv
/*
  Down counter that times one read, write or erase cycle.
  Assumes start and abort come from logic on the same clock and
  that start is only given while the counter is idle.
*/
`timescale 1ns/1ps
`include "eeprom_defs.svh"

module eeprom_cycle_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire eeprom_pkg::count_type load_count,
  output logic done
);
  import eeprom_pkg::*;

  count_type count_reg; // Cycles still to run
  logic run_reg; // Counter active
  logic last_w; // Final cycle of the count

  assign last_w = run_reg && (count_reg <= 24'h000001);
  // End marker stands in the last counted cycle, so the load equals the busy time
  assign done = last_w;

  // Load and count down; the counter stops itself after the last cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 24'h000000;
      run_reg <= 1'b0;
    end else if (abort) begin
      // Aborted cycle reports no end after the abort; done is not masked in the abort cycle itself
      count_reg <= 24'h000000;
      run_reg <= 1'b0;
    end else if (start) begin
      count_reg <= load_count;
      run_reg <= 1'b1;
    end else begin
      count_reg <= run_reg ? count_reg - 24'h000001 : count_reg;
      run_reg <= run_reg && !last_w;
    end
  end

endmodule

//--- tb/emulated_eeprom_access_ctrl_properties.sv
/*
  Port checker of the emulated EEPROM access controller.
  Assumes it is bound onto the controller and sees only its ports.
*/
`timescale 1ns/1ps
module emulated_eeprom_access_ctrl_checker #(
  parameter int unsigned BASE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire eeprom_pkg::reg_index_type addr,
  input wire eeprom_pkg::byte_type wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic low_power_entry,
  input wire eeprom_pkg::byte_type rdata,
  input wire logic cpu_stall,
  input wire logic op_fail
);
  import eeprom_pkg::*;
  // Control write taken while idle
  wire ctl_wr = wr_en && addr == 4'h1 && !cpu_stall;
  logic rden_reg; // Read enable as last written
  logic prog_reg; // Last control write asked for write or erase
  logic arm_reg; // Last strobe set a program enable
  logic [1:0] tsel_reg; // Time select as last written
  logic [4:0] addr_reg; // Address as last written while idle
  int cnt_reg; // Cycles of the running stall
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of what software last wrote while the block was idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rden_reg <= 1'b0;
      prog_reg <= 1'b0;
      arm_reg <= 1'b0;
      tsel_reg <= 2'h0;
      addr_reg <= 5'h00;
      cnt_reg <= 0;
    end else begin
      cnt_reg <= cpu_stall ? cnt_reg + 1 : 0;
      if (wr_en || rd_en) begin
        arm_reg <= ctl_wr && (wdata[3] || wdata[5]);
      end
      if (ctl_wr) begin
        rden_reg <= wdata[1];
        prog_reg <= wdata[2] || wdata[4];
        tsel_reg <= wdata[7:6];
      end
      if (wr_en && addr == 4'h0 && !cpu_stall) begin
        addr_reg <= wdata[4:0];
      end
    end
  end
  property p_go_src; $rose(cpu_stall) |-> $past(ctl_wr); endproperty
  a_go_src: assert property (p_go_src) else $error("stall without control write");
  property p_rd_en; ctl_wr && wdata[0] && !rden_reg |=> !cpu_stall; endproperty
  a_rd_en: assert property (p_rd_en) else $error("read without enable");
  property p_arm; ctl_wr && (wdata[2] || wdata[4]) && !wdata[0] && !arm_reg |=> !cpu_stall;
  endproperty
  a_arm: assert property (p_arm) else $error("program started unarmed");
  property p_rd_len; $rose(cpu_stall) && !prog_reg |-> ##[1:8] !cpu_stall; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read cycle too long");
  property p_prog_len;
    $fell(cpu_stall) && prog_reg && !$past(low_power_entry) |->
      cnt_reg == int'(BASE_CYCLES << tsel_reg);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program time wrong");
  property p_abort; low_power_entry && cpu_stall |=> !cpu_stall && op_fail; endproperty
  a_abort: assert property (p_abort) else $error("low power entry did not fail");
  property p_fail_src; $rose(op_fail) |-> $past(low_power_entry && cpu_stall); endproperty
  a_fail_src: assert property (p_fail_src) else $error("spurious failure flag");
  property p_trig_clr; rd_en && addr == 4'h1 && !cpu_stall |=> rdata[4:0] ==? 5'b0?0?0;
  endproperty
  a_trig_clr: assert property (p_trig_clr) else $error("trigger left set");
  property p_addr; rd_en && addr == 4'h0 |=> rdata == {3'h0, addr_reg}; endproperty
  a_addr: assert property (p_addr) else $error("address register moved");
  c_read: cover property ($rose(cpu_stall) && !prog_reg);
  c_prog: cover property ($fell(cpu_stall) && prog_reg);
  c_abort: cover property (low_power_entry && cpu_stall);
endmodule
bind emulated_eeprom_access_ctrl emulated_eeprom_access_ctrl_checker
  #(.BASE_CYCLES(BASE_CYCLES)) checker_i (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .low_power_entry(low_power_entry),
  .rdata(rdata), .cpu_stall(cpu_stall), .op_fail(op_fail));

//--- tb/emulated_eeprom_access_ctrl_tb.sv
/*
  Self-checking bench of the emulated EEPROM access controller.
  Assumes the controller and its checker are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module emulated_eeprom_access_ctrl_tb;
  import eeprom_pkg::*;
  localparam int unsigned BASE = 8; // Short program time
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_index_type addr = 4'h0;
  byte_type wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic low_power_entry = 1'b0;
  byte_type rdata;
  logic cpu_stall;
  logic op_fail;
  int mismatches = 0;
  int checked = 0;
  int n; // Stall length of the last operation
  logic [31:0] seed = 32'h0000002f;
  word_type mem [32] = '{default: 16'h0000}; // Expected array
  byte_type dat [8]; // Data pair bytes as written
  byte_type exp_q [$]; // Expected read bytes
  byte_type e_cur;
  logic rd_seen = 1'b0; // A read was taken at the last edge
  logic [4:0] a;
  emulated_eeprom_access_ctrl #(.BASE_CYCLES(BASE)) emulated_eeprom_access_ctrl_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .low_power_entry(low_power_entry), .rdata(rdata), .cpu_stall(cpu_stall),
    .op_fail(op_fail));
  // Clock of 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end
  // Xorshift generator for stimulus values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // One write strobe
  task automatic wr(input reg_index_type r, input byte_type d);
    @(posedge clk);
    addr <= r;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // One read strobe; the expected byte is noted for the monitor
  task automatic rd(input reg_index_type r, input byte_type e);
    @(posedge clk);
    addr <= r;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  // Counts stalled cycles until the block is idle again
  task automatic wait_idle();
    n = 0;
    @(negedge clk);
    while (cpu_stall === 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
  endtask
  // Reads one word through the first data pair, read enable already set
  task automatic rd_word(input int i);
    wr(4'h0, 8'(i));
    wr(4'h1, 8'h03);
    wait_idle();
    rd(4'h1, 8'h02);
    rd(4'h2, mem[i][7:0]);
    rd(4'h3, mem[i][15:8]);
    rd(4'h0, 8'(i));
  endtask
  // Prints the counts and the verdict, then stops
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Monitor: compares each read answer with the oldest note
  always @(posedge clk) rd_seen <= rd_en;
  always @(negedge clk) begin
    if (rd_seen) begin
      e_cur = exp_q.pop_front();
      `CHK(rdata, e_cur)
    end
  end
  // Watchdog against a hang
  initial begin
    #40000;
    mismatches++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      a = 5'(rnd());
      wr(4'h0, {3'h0, a});
      for (int k = 0; k < 8; k++) begin
        dat[k] = 8'(rnd());
        wr(4'(2 + k), dat[k]);
      end
      // Enable then trigger with no strobe between, as a masked-interrupt sequence would
      wr(4'h1, 8'(t << 6) | 8'h08);
      wr(4'h1, 8'(t << 6) | 8'h0c);
      wait_idle();
      `CHK(n, BASE << t)
      for (int k = 0; k < 4; k++) mem[{a[4:2], 2'(k)}] = {dat[2 * k + 1], dat[2 * k]};
      rd(4'h1, 8'(t << 6));
    end
    $display("test program done");
    wr(4'h1, 8'h02);
    for (int i = 0; i < 32; i++) rd_word(i);
    $display("test read done");
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h01);
    wait_idle();
    `CHK(n, 0)
    rd(4'h1, 8'h00);
    rd(4'h2, mem[31][7:0]);
    // Several new triggers in one write start nothing
    wr(4'h1, 8'h02);
    wr(4'h1, 8'h17);
    wait_idle();
    `CHK(n, 0)
    rd(4'h1, 8'h02);
    wr(4'h1, 8'h08);
    rd(4'h0, 8'h1f);
    wr(4'h1, 8'h0c);
    wait_idle();
    `CHK(n, 0)
    rd(4'h1, 8'h08);
    $display("test refuse done");
    wr(4'h0, 8'h10);
    wr(4'h1, 8'h20);
    wr(4'h1, 8'h30);
    wr(4'h0, 8'h03);
    wr(4'h3, 8'haa);
    wait_idle();
    rd(4'h1, 8'h00);
    rd(4'h0, 8'h10);
    rd(4'h3, mem[31][15:8]);
    for (int i = 16; i < 32; i++) mem[i] = 16'h0000;
    $display("test erase done");
    wr(4'h2, 8'h5a);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'hc8);
    wr(4'h1, 8'hcc);
    repeat (3) @(posedge clk);
    low_power_entry <= 1'b1;
    @(posedge clk);
    low_power_entry <= 1'b0;
    wait_idle();
    `CHK(op_fail, 1'b1)
    `CHK(n, 0)
    rd(4'h1, 8'hc0);
    wr(4'h1, 8'h02);
    rd_word(0);
    rd_word(20);
    `CHK(op_fail, 1'b0)
    $display("test abort done");
    summarize();
  end
endmodule
